/* File: ccs_charge_ctrl.sv */
// charge state controller: fast or trickle selection with register port
//
// Summary of operation
// - only two states exist, fast and trickle, one bit wide
// - timeout or slope pulse forces trickle over every other input
// - cold at power-up: first warming edge starts fast, later ones do nothing
// - hot at insertion or power-up locks out fast until a new power-up
// - no battery: hold cell count times cap; current at insertion starts fast
// - removal forces trickle and returns to the voltage loop
// - power-up fast needs current sensed, temperature in window, no undervoltage
// - insertion fast needs temperature in window and no undervoltage
// - power-up release starts fast until timeout, slope, a hot crossing, undervoltage or removal ends it
// - in fast, raise sink below sense reference, lower it above
// - trickle raises amplifier gain so current is C/16 for standard rates
// - undervoltage flag blocks fast start while asserted
// - hot threshold crossing ends fast, no restart on cooling
// - power-up release low holds trickle
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module ccs_charge_ctrl (
  input  wire logic                          ref_clk_i,
  input  wire logic                          arst_n_i,
  // condition pins from the analog front end
  input  wire logic                          por_release_i,
  input  wire logic                          under_voltage_i,
  input  wire logic                          in_regulation_i,
  input  wire logic                          temp_above_low_i,
  input  wire logic                          temp_below_high_i,
  input  wire logic                          charge_timeout_i,
  input  wire logic                          slope_terminate_i,
  input  wire logic                          sense_below_ref_i,
  // register port
  input  wire logic [ccs_pkg::ADDR_W-1:0]    reg_addr_i,
  input  wire logic [ccs_pkg::DATA_W-1:0]    reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [ccs_pkg::DATA_W-1:0]    reg_rdata_o,
  // charge control outputs
  output logic                               fast_charge_o,
  output logic                               pass_drive_raise_o,
  output logic                               pass_drive_lower_o,
  output logic      [2:0]                    amp_gain_shift_o,
  output logic                               voltage_loop_o,
  output logic      [ccs_pkg::TARGET_W-1:0]  vreg_target_mv_o
);
  import ccs_pkg::*;

  typedef struct packed {
    ccs_state_t          state;
    logic                hot_lock;
    logic                cold_armed;
    logic                done;
    logic [3:0]          cells_m1;
    ccs_rate_t           rate;
    logic [CAP_W-1:0]    cap_mv;
    logic [DATA_W-1:0]   rdata;
    logic                raise;
    logic                lower;
    logic [2:0]          gain;
    logic                vloop;
    logic [TARGET_W-1:0] target;
  } ccs_core_t;

  ccs_core_t core_reg;
  ccs_core_t core_next;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] lvl;
  logic [PIN_W-1:0] rise;
  logic [PIN_W-1:0] fall;

  // address decode shared by the write and read paths
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] offs);
    addr_hit = (addr == offs);
  endfunction

  // gather the pins in index order
  assign pin_raw[PIN_POR]    = por_release_i;
  assign pin_raw[PIN_UV]     = under_voltage_i;
  assign pin_raw[PIN_INREG]  = in_regulation_i;
  assign pin_raw[PIN_WARM]   = temp_above_low_i;
  assign pin_raw[PIN_COOL]   = temp_below_high_i;
  assign pin_raw[PIN_TMO]    = charge_timeout_i;
  assign pin_raw[PIN_SLOPE]  = slope_terminate_i;
  assign pin_raw[PIN_ISENSE] = sense_below_ref_i;

  // pins come from the analog side, so they are synchronised first
  ccs_sync #(
    .W (PIN_W)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .d_i       (pin_raw),
    .q_o       (lvl)
  );

  // edges from previous-cycle comparison of the filtered levels
  ccs_edge #(
    .W (PIN_W)
  ) u_edge (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .d_i       (lvl),
    .rise_o    (rise),
    .fall_o    (fall)
  );

  // next-state logic for the whole block
  always_comb begin
    logic temp_ok;
    logic uv_ok;
    logic battery_negative_node_cur;
    logic go_fast;
    logic go_trickle;
    logic [4:0] cells;
    temp_ok    = 1'b0;
    uv_ok      = 1'b0;
    battery_negative_node_cur   = 1'b0;
    go_fast    = 1'b0;
    go_trickle = 1'b0;
    cells      = 5'h00;
    core_next  = core_reg;

    // register writes; unmapped offsets are ignored
    if (reg_wr_i) begin
      if (addr_hit(reg_addr_i, ADDR_CTRL)) begin
        core_next.cells_m1 = reg_wdata_i[CTRL_CELLS_LSB +: CTRL_CELLS_W];
        core_next.rate     = ccs_rate_t'(reg_wdata_i[CTRL_RATE_LSB +: CTRL_RATE_W]);
      end
      if (addr_hit(reg_addr_i, ADDR_CAP)) begin
        core_next.cap_mv = reg_wdata_i[CAP_LSB +: CAP_W];
      end
    end

    // read data stands only in the cycle after the strobe
    core_next.rdata = '0;
    if (reg_rd_i) begin
      if (addr_hit(reg_addr_i, ADDR_CTRL)) begin
        core_next.rdata[CTRL_CELLS_LSB +: CTRL_CELLS_W] = core_reg.cells_m1;
        core_next.rdata[CTRL_RATE_LSB +: CTRL_RATE_W]   = core_reg.rate;
      end
      if (addr_hit(reg_addr_i, ADDR_CAP)) begin
        core_next.rdata[CAP_LSB +: CAP_W] = core_reg.cap_mv;
      end
      if (addr_hit(reg_addr_i, ADDR_STAT)) begin
        core_next.rdata[STAT_FAST_BIT]               = (core_reg.state == CCS_FAST);
        core_next.rdata[STAT_HOT_BIT]                = core_reg.hot_lock;
        core_next.rdata[STAT_COLD_BIT]               = core_reg.cold_armed;
        core_next.rdata[STAT_DONE_BIT]               = core_reg.done;
        core_next.rdata[STAT_VLOOP_BIT]              = core_reg.vloop;
        core_next.rdata[STAT_PINS_LSB +: PIN_W]      = lvl;
      end
    end

    // conditions that every fast start needs
    temp_ok  = lvl[PIN_WARM] & lvl[PIN_COOL];
    uv_ok    = ~lvl[PIN_UV];
    battery_negative_node_cur = ~lvl[PIN_INREG];

    if (!lvl[PIN_POR]) begin
      // held in trickle until the supply is up
      core_next.state      = CCS_TRICKLE;
      core_next.cold_armed = 1'b0;
    end else if (rise[PIN_TMO] | rise[PIN_SLOPE]) begin
      // termination wins over any start condition in the same cycle
      core_next.state = CCS_TRICKLE;
      core_next.done  = 1'b1;
    end else if (rise[PIN_POR]) begin
      // power-up release: latch the temperature verdicts of this moment
      core_next.hot_lock   = ~lvl[PIN_COOL];
      core_next.cold_armed = ~lvl[PIN_WARM];
      core_next.done       = 1'b0;
      if (battery_negative_node_cur & temp_ok & uv_ok) begin
        core_next.state = CCS_FAST;
      end
    end else begin
      // events that drop back to trickle
      go_trickle = rise[PIN_UV] | rise[PIN_INREG] | fall[PIN_COOL];
      if (fall[PIN_COOL]) begin
        core_next.hot_lock = 1'b1;
      end
      // a new battery clears the finished mark, but a hot one stays locked
      if (fall[PIN_INREG]) begin
        core_next.done = 1'b0;
        if (!lvl[PIN_COOL]) begin
          core_next.hot_lock = 1'b1;
        end
      end
      // first warming edge after a cold start is spent here
      if (rise[PIN_WARM]) begin
        core_next.cold_armed = 1'b0;
      end
      go_fast = (fall[PIN_UV] | fall[PIN_INREG] | (rise[PIN_WARM] & core_reg.cold_armed))
                & battery_negative_node_cur & temp_ok & uv_ok
                & ~core_next.hot_lock & ~core_next.done;
      if (go_trickle) begin
        core_next.state = CCS_TRICKLE;
      end else if (go_fast) begin
        core_next.state = CCS_FAST;
      end
    end

    // pass transistor steering; voltage limit overrides the current loop
    core_next.raise = lvl[PIN_ISENSE] & ~lvl[PIN_INREG];
    core_next.lower = ~lvl[PIN_ISENSE] | lvl[PIN_INREG];

    // trickle lifts amplifier gain; gain doubles per doubling of rate
    if (core_next.state == CCS_FAST) begin
      core_next.gain = FAST_SHIFT;
    end else begin
      core_next.gain = TRICKLE_SHIFT_BASE + {1'b0, core_next.rate};
    end

    // voltage loop engaged with no battery current while in trickle
    core_next.vloop = (core_next.state == CCS_TRICKLE) & lvl[PIN_INREG];

    // output ceiling is programmed cell count times per-cell cap
    cells            = {1'b0, core_next.cells_m1} + 5'h01;
    // widen both factors first so sixteen cells at a full cap cannot wrap
    core_next.target = TARGET_W'(cells) * TARGET_W'(core_next.cap_mv);
  end

  // single register bank; state clears to trickle
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      core_reg            <= '0;
      core_reg.state      <= CCS_TRICKLE;
      core_reg.cells_m1   <= CELLS_M1_RST;
      core_reg.rate       <= RATE_RST;
      core_reg.cap_mv     <= CAP_MV_RST;
      core_reg.gain       <= TRICKLE_SHIFT_BASE + 3'h1;
      core_reg.lower      <= 1'b1;
      core_reg.target     <= TARGET_W'(CAP_MV_RST);
    end else begin
      core_reg <= core_next;
    end
  end

  // every output straight from the register bank
  assign reg_rdata_o        = core_reg.rdata;
  assign fast_charge_o      = (core_reg.state == CCS_FAST);
  assign pass_drive_raise_o = core_reg.raise;
  assign pass_drive_lower_o = core_reg.lower;
  assign amp_gain_shift_o   = core_reg.gain;
  assign voltage_loop_o     = core_reg.vloop;
  assign vreg_target_mv_o   = core_reg.target;

endmodule

/* File: ccs_pkg.sv */
// shared constants and types for the charge state controller
package ccs_pkg;

  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // byte addresses of the registers
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CAP  = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;

  // control register fields
  localparam int CTRL_CELLS_LSB = 0;
  localparam int CTRL_CELLS_W   = 4;
  localparam int CTRL_RATE_LSB  = 4;
  localparam int CTRL_RATE_W    = 2;

  // cap register field (millivolts per cell)
  localparam int CAP_LSB = 0;
  localparam int CAP_W   = 12;

  // status register field positions
  localparam int STAT_FAST_BIT  = 0;
  localparam int STAT_HOT_BIT   = 1;
  localparam int STAT_COLD_BIT  = 2;
  localparam int STAT_DONE_BIT  = 3;
  localparam int STAT_VLOOP_BIT = 4;
  localparam int STAT_PINS_LSB  = 5;

  // reset values
  localparam logic [3:0]  CELLS_M1_RST = 4'h0;
  localparam logic [11:0] CAP_MV_RST   = 12'h640;

  // synchronised pin indices
  localparam int PIN_W      = 8;
  localparam int PIN_POR    = 0;
  localparam int PIN_UV     = 1;
  localparam int PIN_INREG  = 2;
  localparam int PIN_WARM   = 3;
  localparam int PIN_COOL   = 4;
  localparam int PIN_TMO    = 5;
  localparam int PIN_SLOPE  = 6;
  localparam int PIN_ISENSE = 7;

  // trickle gain: shift of three for C/2, one more per doubling of rate
  localparam logic [2:0] TRICKLE_SHIFT_BASE = 3'h3;
  localparam logic [2:0] FAST_SHIFT         = 3'h0;
  localparam int         TARGET_W           = 17;

  typedef enum logic [0:0] {
    CCS_TRICKLE = 1'b0,
    CCS_FAST    = 1'b1
  } ccs_state_t;

  typedef enum logic [1:0] {
    CCS_RATE_HALF = 2'b00,
    CCS_RATE_1C   = 2'b01,
    CCS_RATE_2C   = 2'b10,
    CCS_RATE_4C   = 2'b11
  } ccs_rate_t;

  localparam ccs_rate_t RATE_RST = CCS_RATE_1C;

endpackage

/* File: ccs_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module ccs_sync #(
  parameter int W = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ccs_sync_t;

  ccs_sync_t sync_reg;
  ccs_sync_t sync_next;

  // s1 feeds only s2; a level counts once s2 and s3 agree
  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = d_i;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    sync_next.q  = (sync_reg.s2 & sync_reg.s3) | (sync_reg.q & (sync_reg.s2 ^ sync_reg.s3));
  end

  // all stages clear to zero under reset
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q_o = sync_reg.q;

endmodule

/* File: ccs_edge.sv */
// edge finder: compares each level with its value one cycle earlier
`timescale 1ns/100ps
module ccs_edge #(
  parameter int W = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  typedef struct packed {
    logic [W-1:0] prev;
  } ccs_edge_t;

  ccs_edge_t edge_reg;
  ccs_edge_t edge_next;

  // previous level kept for comparison
  always_comb begin
    edge_next      = edge_reg;
    edge_next.prev = d_i;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      edge_reg <= '0;
    end else begin
      edge_reg <= edge_next;
    end
  end

  // edges are one-cycle pulses
  assign rise_o = d_i & ~edge_reg.prev;
  assign fall_o = ~d_i & edge_reg.prev;

endmodule

/* File: ccs_charge_ctrl_props.sv */
// checker for the charge state controller outputs
`timescale 1ns/100ps
module ccs_charge_ctrl_props (
  input wire logic       ref_clk_i,
  input wire logic       arst_n_i,
  input wire logic       por_release_i,
  input wire logic       under_voltage_i,
  input wire logic       temp_above_low_i,
  input wire logic       temp_below_high_i,
  input wire logic       charge_timeout_i,
  input wire logic       slope_terminate_i,
  input wire logic       fast_charge_o,
  input wire logic       pass_drive_raise_o,
  input wire logic       pass_drive_lower_o,
  input wire logic [2:0] amp_gain_shift_o,
  input wire logic       voltage_loop_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // long holds give the synchroniser time to pass the level through
  sequence por_held_low;  !por_release_i[*5]; endsequence
  sequence uv_held;       under_voltage_i[*6]; endsequence
  sequence cold_held;     !temp_above_low_i[*6]; endsequence
  AST_DRIVE_COMPLEMENT: assert property (pass_drive_lower_o == !pass_drive_raise_o)
    else $error("drive lower is not the complement of raise");
  AST_GAIN_FAST: assert property (fast_charge_o |-> amp_gain_shift_o == 3'h0)
    else $error("gain shift not zero in fast");
  AST_GAIN_TRICKLE: assert property (!fast_charge_o |-> amp_gain_shift_o inside {[3:6]})
    else $error("trickle gain shift out of range");
  AST_POR_LOW_TRICKLE: assert property (por_held_low |=> !fast_charge_o)
    else $error("fast while power-up release low");
  AST_TIMEOUT_TRICKLE: assert property ($rose(charge_timeout_i) |-> ##[1:6] !fast_charge_o)
    else $error("timeout did not force trickle");
  AST_SLOPE_TRICKLE: assert property ($rose(slope_terminate_i) |-> ##[1:6] !fast_charge_o)
    else $error("slope event did not force trickle");
  AST_HOT_ENDS_FAST: assert property ($fell(temp_below_high_i) |-> ##[1:6] !fast_charge_o)
    else $error("hot crossing did not end fast");
  AST_VLOOP_TRICKLE: assert property (voltage_loop_o |-> !fast_charge_o)
    else $error("voltage loop active in fast");
  AST_UV_BLOCKS: assert property (uv_held |=> !fast_charge_o)
    else $error("fast during undervoltage");
  AST_COLD_NO_START: assert property (cold_held |=> !$rose(fast_charge_o))
    else $error("fast started while cold");
endmodule
bind ccs_charge_ctrl ccs_charge_ctrl_props u_props (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .por_release_i(por_release_i),
  .under_voltage_i(under_voltage_i), .temp_above_low_i(temp_above_low_i),
  .temp_below_high_i(temp_below_high_i), .charge_timeout_i(charge_timeout_i),
  .slope_terminate_i(slope_terminate_i), .fast_charge_o(fast_charge_o),
  .pass_drive_raise_o(pass_drive_raise_o), .pass_drive_lower_o(pass_drive_lower_o),
  .amp_gain_shift_o(amp_gain_shift_o), .voltage_loop_o(voltage_loop_o)
);

/* File: ccs_battery_model.sv */
// battery pack model: thermistors, cell level and current sense
`timescale 1ns/100ps
module ccs_battery_model (
  input  wire logic ref_clk_i,
  input  wire logic present_i,
  input  wire logic cold_i,
  input  wire logic hot_i,
  input  wire logic low_cell_i,
  input  wire logic cur_high_i,
  output logic      under_voltage_o,
  output logic      in_regulation_o,
  output logic      temp_above_low_o,
  output logic      temp_below_high_o,
  output logic      sense_below_ref_o
);
  // pins move just after the edge, like a real comparator bank
  initial begin
    under_voltage_o   = 1'b0;
    in_regulation_o   = 1'b1;
    temp_above_low_o  = 1'b1;
    temp_below_high_o = 1'b1;
    sense_below_ref_o = 1'b1;
  end
  always @(posedge ref_clk_i) begin
    under_voltage_o   <= low_cell_i;
    in_regulation_o   <= !present_i;               // no pack, no current
    temp_above_low_o  <= !cold_i;
    temp_below_high_o <= !hot_i;
    sense_below_ref_o <= !present_i || !cur_high_i; // empty loop reads below ref
  end
endmodule

/* File: ccs_charge_ctrl_bench.sv */
// self-checking bench for the charge state controller
`timescale 1ns/100ps
module ccs_charge_ctrl_bench;
  import ccs_pkg::*;
  logic ref_clk_i = 1'b0, arst_n_i = 1'b0, por = 1'b0, tmo = 1'b0, slope = 1'b0;
  logic present = 1'b1, cold = 1'b0, hot = 1'b0, low_cell = 1'b0, cur_high = 1'b0;
  logic uv, inreg, warm, cool, below, wr = 1'b0, rd = 1'b0;
  logic fast, raise, lower, vloop;
  logic [ADDR_W-1:0]   addr = '0;
  logic [DATA_W-1:0]   wdata = '0, rdata, rv;
  logic [2:0]          gain;
  logic [TARGET_W-1:0] target;
  int fail_count = 0, cmp_count = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  ccs_battery_model u_bat (.ref_clk_i(ref_clk_i), .present_i(present), .cold_i(cold),
    .hot_i(hot), .low_cell_i(low_cell), .cur_high_i(cur_high), .under_voltage_o(uv),
    .in_regulation_o(inreg), .temp_above_low_o(warm), .temp_below_high_o(cool),
    .sense_below_ref_o(below));
  ccs_charge_ctrl u_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .por_release_i(por),
    .under_voltage_i(uv), .in_regulation_i(inreg), .temp_above_low_i(warm),
    .temp_below_high_i(cool), .charge_timeout_i(tmo), .slope_terminate_i(slope),
    .sense_below_ref_i(below), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .fast_charge_o(fast), .pass_drive_raise_o(raise),
    .pass_drive_lower_o(lower), .amp_gain_shift_o(gain), .voltage_loop_o(vloop),
    .vreg_target_mv_o(target));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge ref_clk_i) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge ref_clk_i) begin rd <= 1'b1; addr <= a; end
    @(posedge ref_clk_i) rd <= 1'b0;
    #1 rv = rdata;   // read data stand only in this cycle
  endtask
  // pins pass the model, three sync stages and the filter, state follows one edge later
  task automatic settle(); repeat (6) @(posedge ref_clk_i); #1; endtask
  task automatic por_cycle();
    @(posedge ref_clk_i) por <= 1'b0;
    settle();
    @(posedge ref_clk_i) por <= 1'b1;
    settle();
  endtask
  task automatic pulse_tmo();
    @(posedge ref_clk_i) tmo <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    tmo <= 1'b0;
    settle();
  endtask
  task automatic t_reset();
    chk(gain, 32'h0000_0004); chk(target, 32'h0000_0640); chk(fast, 0);
    rd_reg(ADDR_CTRL); chk(rv, 32'h0000_0010);
    rd_reg(ADDR_CAP); chk(rv, 32'h0000_0640);
    rd_reg(4'hC); chk(rv, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_power_up();
    por_cycle(); chk(fast, 1); chk(gain, 0);
    pulse_tmo(); chk(fast, 0); chk(gain, 4);
    $display("test power_up done");
  endtask
  task automatic t_rates();
    for (int r = 0; r < 4; r++) begin
      wr_reg(ADDR_CTRL, 32'h0000_0003 | (r << 4)); #1 chk(gain, 3 + r);
    end
    wr_reg(ADDR_CAP, 32'h0000_05DC); #1 chk(target, 32'h0000_1770);
    rd_reg(ADDR_CTRL); chk(rv, 32'h0000_0033);
    wr_reg(ADDR_CTRL, 32'h0000_0010);
    $display("test rates done");
  endtask
  task automatic t_hot();
    hot <= 1'b1; por_cycle(); chk(fast, 0);
    hot <= 1'b0; settle(); chk(fast, 0);
    por_cycle(); chk(fast, 1);
    hot <= 1'b1; settle(); chk(fast, 0);
    hot <= 1'b0; settle(); chk(fast, 0);
    $display("test hot done");
  endtask
  task automatic t_cold();
    cold <= 1'b1; por_cycle(); chk(fast, 0);
    cold <= 1'b0; settle(); chk(fast, 1);
    @(posedge ref_clk_i) slope <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    slope <= 1'b0; settle(); chk(fast, 0);
    cold <= 1'b1; settle(); cold <= 1'b0; settle(); chk(fast, 0);
    $display("test cold done");
  endtask
  task automatic t_insert();
    present <= 1'b0; settle(); chk(vloop, 1); chk(fast, 0);
    present <= 1'b1; settle(); chk(fast, 1); chk(vloop, 0);
    present <= 1'b0; settle(); chk(fast, 0); chk(vloop, 1);
    rd_reg(ADDR_STAT); chk(rv, 32'h0000_13B0);
    $display("test insert done");
  endtask
  task automatic t_uv();
    low_cell <= 1'b1; present <= 1'b1; settle(); chk(fast, 0);
    low_cell <= 1'b0; settle(); chk(fast, 1);
    $display("test undervoltage done");
  endtask
  task automatic t_drive();
    cur_high <= 1'b0; settle(); chk(raise, 1); chk(lower, 0);
    cur_high <= 1'b1; settle(); chk(raise, 0); chk(lower, 1);
    @(posedge ref_clk_i) por <= 1'b0;
    settle(); chk(fast, 0);
    $display("test drive done");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog well past the few hundred cycles the tests need
  initial begin
    #200us;
    fail_count++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    settle();
    t_reset(); t_power_up(); t_rates(); t_hot(); t_cold(); t_insert(); t_uv(); t_drive();
    conclude();
  end
endmodule
